// ### design/rslp_pkg.sv
package rslp_pkg;

  // register word offsets (byte addresses)
  localparam logic [7:0] ADR_SYS_CTRL_TWO   = 8'h00;
  localparam logic [7:0] ADR_TIMER_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADR_EVT_STATUS     = 8'h08;
  localparam logic [7:0] ADR_EVT_CLEAR      = 8'h0c;
  localparam logic [7:0] ADR_EVT_ENABLE     = 8'h10;
  localparam logic [7:0] ADR_RST_CAUSE      = 8'h14;

  // sys_control_reg_two fields
  localparam int SCR_LP_ENABLE   = 0;
  localparam int SCR_OSC_DET_OFF = 2;
  localparam int SCR_OSC_RST_EN  = 5;
  localparam int SCR_MODE_LO     = 6;
  localparam int SCR_MODE_HI     = 7;
  localparam logic [7:0] SCR_RESET = 8'h00;

  // timer_one_control_reg_two fields
  localparam int TCR_WD_FLAG = 5;
  localparam int TCR_WD_RSTEN = 7;

  // event bits, shared by status, clear, enable and cause
  localparam int EVT_WD     = 0;
  localparam int EVT_OSC    = 1;
  localparam int EVT_EXT    = 2;
  localparam int EVT_KEY    = 3;
  localparam int EVT_LP     = 4;
  localparam int EVT_W      = 5;

  // default mode select encodings
  localparam logic [1:0] MODE_HALT_DEF    = 2'h3;
  localparam logic [1:0] MODE_STANDBY_DEF = 2'h2;
  localparam logic [1:0] MODE_IDLE_DEF    = 2'h1;

  // system reset pulse length
  localparam int CLK_PERIOD_PS  = 4000;
  localparam int SYS_RST_MIN_NS = 100;
  localparam int SYS_RST_CYCLES =
    (SYS_RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } rslp_wb_req_t;

  typedef struct packed {
    logic wd_overflow;
    logic wd_key_error;
    logic lp_request;
    logic lp_wake;
  } rslp_core_evt_t;

  typedef enum logic [1:0] {
    LP_RUN,
    LP_IDLE,
    LP_STANDBY,
    LP_HALT
  } rslp_lp_state_t;

endpackage : rslp_pkg

// ### design/rslp_sync.sv
`timescale 1ns/1ps
module rslp_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // level in and out
  input  wire logic din,
  output logic      dout
);

  logic meta_q;

  // first stage feeds only the second
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_q <= RESET_VAL;
      dout   <= RESET_VAL;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule : rslp_sync

// ### design/rslp_rst_pulse.sv
`timescale 1ns/1ps
module rslp_rst_pulse #(
  parameter int CYCLES = rslp_pkg::SYS_RST_CYCLES
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // trigger and stretched reset
  input  wire logic start,
  output logic      busy_q
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // triggers while busy reload the count, stretching the running pulse
  assign cnt_d = start ? LOAD :
                 (cnt_q != '0) ? cnt_q - CW'(1) : cnt_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= (cnt_d != '0);
    end
  end

endmodule : rslp_rst_pulse

// ### design/rslp_top.sv
// Operation
// - mode bits 6 and 7 of system control two pick halt, standby, idle
// - mask variant contact option can disable halt and standby for good
// - other variants enable halt and standby only through software bit 0; idle needs no enable
// - newer revision: timer control two bit 5 set after watchdog reset
// - newer: flag cleared by writing zero or non-watchdog reset only
// - newer: watchdog overflow resets regardless of the flag
// - original: flag marks overflow; clearing depends on reset enable
// - original: overflow does not reset while the flag stays set
// - newer: reset enable bit 7 cleared by every system reset
// - original: reset enable cleared only by power-up reset
// - newer: system control two bit 2 reserved, writes have no effect
// - newer: oscillator fault always resets; bit 5 reserved
// - original: bit 5 enables fault reset when detect-off is clear
`timescale 1ns/1ps
module rslp_top #(
  parameter logic       REV_NEWER      = 1'b1,
  parameter logic       MASK_VARIANT   = 1'b0,
  parameter logic       LP_CONTACT_OFF = 1'b0,
  parameter logic [1:0] MODE_HALT      = rslp_pkg::MODE_HALT_DEF,
  parameter logic [1:0] MODE_STANDBY   = rslp_pkg::MODE_STANDBY_DEF,
  parameter logic [1:0] MODE_IDLE      = rslp_pkg::MODE_IDLE_DEF,
  parameter int         RST_CYCLES     = rslp_pkg::SYS_RST_CYCLES
) (
  // clock and power-up reset
  input  wire logic                   mclk,
  input  wire logic                   rst,
  // wishbone slave
  input  wire rslp_pkg::rslp_wb_req_t wb_req,
  output logic                        wb_ack_o,
  output logic [31:0]                 wb_dat_o,
  // core events, same clock
  input  wire rslp_pkg::rslp_core_evt_t core_evt,
  // pins
  input  wire logic                   osc_fault,
  input  wire logic                   ext_reset_n,
  // system reset and low-power state
  output logic                        sys_reset_o,
  output logic                        lp_halt_o,
  output logic                        lp_standby_o,
  output logic                        lp_idle_o,
  // interrupt
  output logic                        irq_o
);

  localparam int EW = rslp_pkg::EVT_W;

  // byte lane 0 write helper, used for system control two and the event clear and enable writes
  function automatic logic [7:0] lane0(input logic [7:0] old,
                                       input logic [3:0] sel,
                                       input logic [31:0] dat);
    lane0 = sel[0] ? dat[7:0] : old;
  endfunction : lane0

  // address match, shared by every write strobe
  function automatic logic adr_hit(input logic [7:0] adr,
                                   input logic [7:0] off);
    adr_hit = (adr == off);
  endfunction : adr_hit

  // synchronised pins
  logic osc_fault_s;
  logic ext_reset_n_s;

  rslp_sync #(.RESET_VAL(1'b0)) u_sync_osc (
    .mclk (mclk),
    .rst  (rst),
    .din  (osc_fault),
    .dout (osc_fault_s)
  );

  rslp_sync #(.RESET_VAL(1'b1)) u_sync_ext (
    .mclk (mclk),
    .rst  (rst),
    .din  (ext_reset_n),
    .dout (ext_reset_n_s)
  );

  // registers
  logic [7:0]    scr_q;
  logic [7:0]    scr_d;
  logic          wd_flag_q;
  logic          wd_flag_d;
  logic          wd_rsten_q;
  logic          wd_rsten_d;
  logic [EW-1:0] evt_status_q;
  logic [EW-1:0] evt_status_d;
  logic [EW-1:0] evt_en_q;
  logic [EW-1:0] evt_en_d;
  logic [EW-1:0] cause_q;
  logic [EW-1:0] cause_d;
  rslp_pkg::rslp_lp_state_t lp_q;
  rslp_pkg::rslp_lp_state_t lp_d;

  // bus decode; write lands on the edge where ack is seen
  wire bus_req  = wb_req.cyc & wb_req.stb;
  wire bus_wr   = bus_req & wb_req.we & wb_ack_o;
  wire wr_scr   = bus_wr & adr_hit(wb_req.adr, rslp_pkg::ADR_SYS_CTRL_TWO);
  wire wr_tcr   = bus_wr & adr_hit(wb_req.adr, rslp_pkg::ADR_TIMER_CTRL_TWO);
  wire wr_clr   = bus_wr & adr_hit(wb_req.adr, rslp_pkg::ADR_EVT_CLEAR);
  wire wr_en    = bus_wr & adr_hit(wb_req.adr, rslp_pkg::ADR_EVT_ENABLE);
  wire [7:0] wr_byte = lane0(8'h00, wb_req.sel, wb_req.dat);

  // reserved bits on the newer revision read zero
  wire [7:0] scr_mask = REV_NEWER ? ~((8'h01 << rslp_pkg::SCR_OSC_DET_OFF)
                                     | (8'h01 << rslp_pkg::SCR_OSC_RST_EN))
                                  : 8'hff;
  wire [7:0] scr_rd = scr_q & scr_mask;
  wire [7:0] tcr_rd = ({7'h00, wd_rsten_q} << rslp_pkg::TCR_WD_RSTEN)
                    | ({7'h00, wd_flag_q} << rslp_pkg::TCR_WD_FLAG);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_req.adr)
      rslp_pkg::ADR_SYS_CTRL_TWO:   rd_mux = {24'h00_0000, scr_rd};
      rslp_pkg::ADR_TIMER_CTRL_TWO: rd_mux = {24'h00_0000, tcr_rd};
      rslp_pkg::ADR_EVT_STATUS:     rd_mux = {27'h000_0000, evt_status_q};
      rslp_pkg::ADR_EVT_ENABLE:     rd_mux = {27'h000_0000, evt_en_q};
      rslp_pkg::ADR_RST_CAUSE:      rd_mux = {27'h000_0000, cause_q};
      default:                      rd_mux = 32'h0000_0000;
    endcase
  end

  // reset trigger sources
  logic sys_busy;
  wire wd_ov  = core_evt.wd_overflow;
  // original keeps a set flag as a block on further watchdog resets
  wire wd_trip = wd_ov & wd_rsten_q
               & (REV_NEWER | ~wd_flag_q);
  // original needs detect-off clear; software keeps it clear
  wire osc_trip = osc_fault_s
                & (REV_NEWER | (scr_q[rslp_pkg::SCR_OSC_RST_EN]
                   & ~scr_q[rslp_pkg::SCR_OSC_DET_OFF]));
  wire ext_trip = ~ext_reset_n_s;
  wire key_trip = core_evt.wd_key_error;
  wire any_trip = (wd_trip | osc_trip | ext_trip | key_trip) & ~sys_busy;
  // pin and fault sources win over the watchdog when they coincide
  wire is_wd_rst = wd_trip & ~osc_trip & ~ext_trip & ~key_trip;

  wire [EW-1:0] trip_vec;
  assign trip_vec[rslp_pkg::EVT_WD]  = is_wd_rst;
  assign trip_vec[rslp_pkg::EVT_OSC] = osc_trip;
  assign trip_vec[rslp_pkg::EVT_EXT] = ext_trip;
  assign trip_vec[rslp_pkg::EVT_KEY] = key_trip;
  assign trip_vec[rslp_pkg::EVT_LP]  = 1'b0;

  rslp_rst_pulse #(.CYCLES(RST_CYCLES)) u_rst_pulse (
    .mclk   (mclk),
    .rst    (rst),
    .start  (any_trip),
    .busy_q (sys_busy)
  );

  // watchdog flag
  always_comb begin
    wd_flag_d = wd_flag_q;
    if (wr_tcr & wb_req.sel[0] & ~wb_req.dat[rslp_pkg::TCR_WD_FLAG])
      wd_flag_d = 1'b0;
    if (REV_NEWER) begin
      if (any_trip)
        wd_flag_d = is_wd_rst;
    end else begin
      if (any_trip & ~wd_rsten_q)
        wd_flag_d = 1'b0;
      if (wd_ov)
        wd_flag_d = 1'b1;
    end
  end

  // watchdog reset enable
  always_comb begin
    wd_rsten_d = wd_rsten_q;
    if (wr_tcr & wb_req.sel[0])
      wd_rsten_d = wb_req.dat[rslp_pkg::TCR_WD_RSTEN];
    if (REV_NEWER & any_trip)
      wd_rsten_d = 1'b0;
    // original: only the power-up reset clears it
  end

  // system control two, cleared by any system reset
  always_comb begin
    scr_d = scr_q;
    if (wr_scr)
      scr_d = lane0(scr_q, wb_req.sel, wb_req.dat);
    if (any_trip)
      scr_d = rslp_pkg::SCR_RESET;
  end

  // low-power mode control
  wire [1:0] mode_sel = scr_q[rslp_pkg::SCR_MODE_HI:rslp_pkg::SCR_MODE_LO];
  // contact option only exists on mask variants
  wire lp_contact_ok = ~(MASK_VARIANT & LP_CONTACT_OFF);
  wire lp_allowed = lp_contact_ok
                  & scr_q[rslp_pkg::SCR_LP_ENABLE];
  wire lp_enter = core_evt.lp_request & (lp_q == rslp_pkg::LP_RUN)
                & ~sys_busy;

  always_comb begin
    lp_d = lp_q;
    if (lp_enter) begin
      if (mode_sel == MODE_IDLE)
        lp_d = rslp_pkg::LP_IDLE;
      else if ((mode_sel == MODE_HALT) & lp_allowed)
        lp_d = rslp_pkg::LP_HALT;
      else if ((mode_sel == MODE_STANDBY) & lp_allowed)
        lp_d = rslp_pkg::LP_STANDBY;
    end else if (core_evt.lp_wake) begin
      lp_d = rslp_pkg::LP_RUN;
    end
    if (any_trip | sys_busy)
      lp_d = rslp_pkg::LP_RUN;
  end

  wire lp_entered = (lp_q == rslp_pkg::LP_RUN)
                  & (lp_d != rslp_pkg::LP_RUN);

  // interrupt status; a set in the clearing cycle wins
  wire [EW-1:0] evt_set = (any_trip ? trip_vec : '0)
                        | ({{(EW-1){1'b0}}, lp_entered} << rslp_pkg::EVT_LP);
  wire [EW-1:0] clr_bits = wr_clr ? wr_byte[EW-1:0] : '0;
  assign evt_status_d = (evt_status_q & ~clr_bits) | evt_set;
  assign evt_en_d = wr_en ? wr_byte[EW-1:0] : evt_en_q;
  assign cause_d = any_trip ? trip_vec : cause_q;

  // control state; system resets act through the _d terms
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scr_q <= rslp_pkg::SCR_RESET;
      lp_q  <= rslp_pkg::LP_RUN;
    end else begin
      scr_q <= scr_d;
      lp_q  <= lp_d;
    end
  end

  // only the power-up reset reaches these directly
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wd_flag_q  <= 1'b0;
      wd_rsten_q <= 1'b0;
    end else begin
      wd_flag_q  <= wd_flag_d;
      wd_rsten_q <= wd_rsten_d;
    end
  end

  // event registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      evt_status_q <= '0;
      evt_en_q     <= '0;
      cause_q      <= '0;
    end else begin
      evt_status_q <= evt_status_d;
      evt_en_q     <= evt_en_d;
      cause_q      <= cause_d;
    end
  end

  // output next values; outputs follow lp_d so they lag no cycle
  wire lp_halt_d    = (lp_d == rslp_pkg::LP_HALT);
  wire lp_standby_d = (lp_d == rslp_pkg::LP_STANDBY);
  wire lp_idle_d    = (lp_d == rslp_pkg::LP_IDLE);
  wire sys_reset_d  = any_trip | sys_busy;
  wire irq_d        = |(evt_status_d & evt_en_d);
  // one-cycle ack; a held request gets a gap before the next
  wire ack_d        = bus_req & ~wb_ack_o;

  // registered outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h0000_0000;
      sys_reset_o  <= 1'b0;
      lp_halt_o    <= 1'b0;
      lp_standby_o <= 1'b0;
      lp_idle_o    <= 1'b0;
      irq_o        <= 1'b0;
    end else begin
      wb_ack_o     <= ack_d;
      wb_dat_o     <= rd_mux;
      sys_reset_o  <= sys_reset_d;
      lp_halt_o    <= lp_halt_d;
      lp_standby_o <= lp_standby_d;
      lp_idle_o    <= lp_idle_d;
      irq_o        <= irq_d;
    end
  end

endmodule : rslp_top

// ### test/rslp_top_sva.sv
`timescale 1ns/1ps
module rslp_top_sva #(
  parameter int RST_CYCLES = 2
) (
  // clock and reset
  input wire logic                     mclk,
  input wire logic                     rst,
  // bus
  input wire rslp_pkg::rslp_wb_req_t   wb_req,
  input wire logic                     wb_ack_o,
  input wire logic [31:0]              wb_dat_o,
  // events and pins
  input wire rslp_pkg::rslp_core_evt_t core_evt,
  input wire logic                     osc_fault,
  input wire logic                     ext_reset_n,
  // outputs
  input wire logic                     sys_reset_o,
  input wire logic                     lp_halt_o,
  input wire logic                     lp_standby_o,
  input wire logic                     lp_idle_o,
  input wire logic                     irq_o
);
  logic [7:0] hi_q;
  wire        any_lp = lp_halt_o | lp_standby_o | lp_idle_o;
  // length counter, a repetition cannot take the parameter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) hi_q <= 8'h00;
    else hi_q <= sys_reset_o ? hi_q + 8'h01 : 8'h00;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_ack_resp;
    wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_key_trip;
    core_evt.wd_key_error && !sys_reset_o |=> sys_reset_o;
  endproperty
  a_key_trip: assert property (p_key_trip) else $error("no key reset");
  property p_osc_trip;
    $rose(osc_fault) |-> ##[1:4] sys_reset_o;
  endproperty
  a_osc_trip: assert property (p_osc_trip) else $error("no osc reset");
  property p_ext_trip;
    $fell(ext_reset_n) |-> ##[1:4] sys_reset_o;
  endproperty
  a_ext_trip: assert property (p_ext_trip) else $error("no ext reset");
  property p_rst_len;
    $fell(sys_reset_o) |-> hi_q == 8'(RST_CYCLES + 1);
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset length");
  property p_lp_cause;
    $rose(any_lp) |-> $past(core_evt.lp_request);
  endproperty
  a_lp_cause: assert property (p_lp_cause) else $error("lp no request");
  property p_lp_wake;
    core_evt.lp_wake && any_lp |=> !any_lp;
  endproperty
  a_lp_wake: assert property (p_lp_wake) else $error("no wake");
  property p_trip_run;
    $rose(sys_reset_o) |-> !any_lp;
  endproperty
  a_trip_run: assert property (p_trip_run) else $error("lp in reset");
  property p_onehot;
    $onehot0({lp_halt_o, lp_standby_o, lp_idle_o});
  endproperty
  a_onehot: assert property (p_onehot) else $error("two modes");
  c_trip: cover property ($rose(sys_reset_o));
  c_halt: cover property ($rose(lp_halt_o));
  c_irq: cover property ($rose(irq_o));
endmodule : rslp_top_sva

bind rslp_top rslp_top_sva #(.RST_CYCLES(RST_CYCLES)) rslp_top_sva_i (
  .mclk(mclk), .rst(rst), .wb_req(wb_req), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .core_evt(core_evt), .osc_fault(osc_fault),
  .ext_reset_n(ext_reset_n), .sys_reset_o(sys_reset_o),
  .lp_halt_o(lp_halt_o), .lp_standby_o(lp_standby_o),
  .lp_idle_o(lp_idle_o), .irq_o(irq_o));

// ### test/rslp_tb_top.sv
`timescale 1ns/1ps
module rslp_tb_top;
  typedef struct packed {
    logic       we;
    logic [7:0] adr;
    logic [7:0] dat;
    logic [7:0] exp;
  } rslp_row_t;
  localparam rslp_row_t ROWS [10] = '{
    '{1'b1, 8'h00, 8'hc5, 8'h00}, '{1'b0, 8'h00, 8'h00, 8'hc1},
    '{1'b1, 8'h04, 8'ha0, 8'h00}, '{1'b0, 8'h04, 8'h00, 8'h80},
    '{1'b1, 8'h10, 8'h1f, 8'h00}, '{1'b0, 8'h10, 8'h00, 8'h1f},
    '{1'b1, 8'h18, 8'hff, 8'h00}, '{1'b0, 8'h18, 8'h00, 8'h00},
    '{1'b0, 8'h08, 8'h00, 8'h00}, '{1'b0, 8'h0c, 8'h00, 8'h00}};
  logic                     mclk = 1'b0;
  logic                     rst = 1'b1;
  rslp_pkg::rslp_wb_req_t   wb_req = '0;
  rslp_pkg::rslp_core_evt_t core_evt = '0;
  logic                     osc_fault = 1'b0;
  logic                     ext_reset_n = 1'b1;
  logic                     wb_ack_o, sys_reset_o, irq_o;
  logic                     lp_halt_o, lp_standby_o, lp_idle_o;
  logic [31:0]              wb_dat_o, rd;
  logic [1:0]               m;
  int                       err_total = 0, checked = 0, cyc_n = 0;

  rslp_top #(.REV_NEWER(1'b1), .RST_CYCLES(2)) rslp_top_i (
    .mclk(mclk), .rst(rst), .wb_req(wb_req), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .core_evt(core_evt), .osc_fault(osc_fault),
    .ext_reset_n(ext_reset_n), .sys_reset_o(sys_reset_o),
    .lp_halt_o(lp_halt_o), .lp_standby_o(lp_standby_o),
    .lp_idle_o(lp_idle_o), .irq_o(irq_o));

  always #2 mclk = ~mclk;

  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  // run ceiling, over thirty times the expected length
  always @(posedge mclk) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      err_total++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [7:0] d);
    int n;
    n = 0;
    wb_req <= '{1'b1, 1'b1, we, adr, 4'h1, {24'h0, d}};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    rd = wb_dat_o;
    if (n >= 40) chk("ack", 1'b0, 1'b1);
    wb_req <= '0;
    @(posedge mclk);
  endtask : wb

  task automatic rdchk(input string nm, input logic [7:0] adr,
                       input logic [7:0] exp);
    wb(1'b0, adr, 8'h00);
    chk(nm, rd, {24'h0, exp});
  endtask : rdchk

  task automatic pulse(input rslp_pkg::rslp_core_evt_t e);
    core_evt <= e;
    @(posedge mclk);
    core_evt <= '0;
    @(posedge mclk);
  endtask : pulse

  // waits out a whole system reset so no bus cycle lands inside it
  task automatic wait_sys;
    int n;
    n = 0;
    while (sys_reset_o !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    chk("sys_reset", sys_reset_o, 1'b1);
    while (sys_reset_o !== 1'b0 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
  endtask : wait_sys

  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk("sys_reset idle", sys_reset_o, 1'b0);
    foreach (ROWS[i]) begin
      wb(ROWS[i].we, ROWS[i].adr, ROWS[i].dat);
      if (!ROWS[i].we) chk("row read", rd, {24'h0, ROWS[i].exp});
    end
    $display("register rows done");
    for (int k = 1; k < 4; k++) begin
      m = k[1:0];
      wb(1'b1, 8'h00, {m, 6'h01});
      pulse(4'b0010);
      chk("lp mode", {lp_halt_o, lp_standby_o, lp_idle_o},
          {m == rslp_pkg::MODE_HALT_DEF, m == rslp_pkg::MODE_STANDBY_DEF,
           m == rslp_pkg::MODE_IDLE_DEF});
      pulse(4'b0001);
      chk("lp wake", {lp_halt_o, lp_standby_o, lp_idle_o}, 3'b000);
    end
    wb(1'b1, 8'h00, {rslp_pkg::MODE_HALT_DEF, 6'h00});
    pulse(4'b0010);
    chk("halt off", lp_halt_o, 1'b0);
    wb(1'b1, 8'h0c, 8'h1f);
    chk("irq cleared", irq_o, 1'b0);
    $display("low power done");
    pulse(4'b1000);
    wait_sys();
    rdchk("flag set", 8'h04, 8'h20);
    rdchk("cause wd", 8'h14, 8'h01);
    rdchk("status wd", 8'h08, 8'h01);
    chk("irq", irq_o, 1'b1);
    wb(1'b1, 8'h04, 8'ha0);
    pulse(4'b1000);
    wait_sys();
    rdchk("flag kept", 8'h04, 8'h20);
    pulse(4'b0100);
    wait_sys();
    rdchk("flag off", 8'h04, 8'h00);
    rdchk("cause key", 8'h14, 8'h08);
    osc_fault <= 1'b1;
    @(posedge mclk);
    osc_fault <= 1'b0;
    wait_sys();
    rdchk("cause osc", 8'h14, 8'h02);
    ext_reset_n <= 1'b0;
    @(posedge mclk);
    ext_reset_n <= 1'b1;
    wait_sys();
    rdchk("cause ext", 8'h14, 8'h04);
    wb(1'b1, 8'h0c, 8'h1f);
    rdchk("status clr", 8'h08, 8'h00);
    chk("irq low", irq_o, 1'b0);
    $display("reset sources done");
    test_done();
  end
endmodule : rslp_tb_top
